// file: core/evq_top.sv
// event queue stage with register slave and two transfer request ports
`timescale 1ns/1ps
module evq_top
  import evq_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_EVT_VALID,
  input wire evq_entry_t I_EVT,
  output logic O_EVT_READY,
  output logic [EVQ_NQ-1:0] O_TR_VALID,
  output evq_req_t [EVQ_NQ-1:0] O_TR,
  input wire logic [EVQ_NQ-1:0] I_TR_READY,
  input wire logic [EVQ_NQ-1:0] I_ENG_EMPTY,
  output logic O_IRQ,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [EVQ_AW-1:0] I_AXI_AWADDR,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  output logic [1:0] O_AXI_BRESP,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  input wire logic [EVQ_AW-1:0] I_AXI_ARADDR,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP
);
  logic [EVQ_NDMA-1:0] dsel_ff;
  logic [EVQ_NQUICK-1:0] qsel_ff;
  logic [3:0] thr_ff [EVQ_NQ];
  logic [2:0] prio_ff [EVQ_NQ];
  logic [EVQ_NQ-1:0] mask_ff;
  logic [EVQ_NQ-1:0] err_ff;
  logic [3:0] head_ff [EVQ_NQ];
  logic [4:0] count_ff [EVQ_NQ];
  logic [4:0] mark_ff [EVQ_NQ];
  logic [4:0] nxt_count [EVQ_NQ];
  logic [3:0] wr_idx [EVQ_NQ];
  logic [EVQ_NQ-1:0] over_ff;
  logic [EVQ_NQ-1:0] tr_valid_ff;
  evq_entry_t tr_ent_ff [EVQ_NQ];
  evq_entry_t entry_mem [EVQ_NQ][EVQ_DEPTH];
  logic [EVQ_NQ-1:0] elig;
  logic [EVQ_NQ-1:0] deq;
  logic [EVQ_NQ-1:0] enq;
  logic [EVQ_NQ-1:0] byp;
  logic [EVQ_NQ-1:0] over_set;
  logic evt_q;
  logic evt_ok;
  logic aw_got_ff;
  logic w_got_ff;
  logic [EVQ_AW-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;
  logic ar_fire;
  logic err_rd_clr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] stat_word(input logic [3:0] hd,
                                            input logic [4:0] cnt,
                                            input logic [4:0] mk,
                                            input logic ov);
    logic [31:0] r;
    r = 32'h0;
    r[3:0] = hd;
    r[EVQ_POS_COUNT +: 5] = cnt;
    r[EVQ_POS_MARK +: 5] = mk;
    r[EVQ_POS_OVER] = ov;
    return r;
  endfunction : stat_word

  // queue choice per channel; quick channels use their own select bits
  always_comb
  begin
    if (I_EVT.kind == EVQ_K_QUICK)
    begin
      evt_q = qsel_ff[I_EVT.chan[2:0]];
    end
    else
    begin
      evt_q = dsel_ff[I_EVT.chan];
    end
  end

  // a full queue refuses, so the event stays pending upstream
  assign evt_ok = I_EVT_VALID && (count_ff[evt_q] != 5'(EVQ_DEPTH));
  assign O_EVT_READY = evt_ok;

  // one dequeue per cycle through the shared parameter path
  assign deq[0] = elig[0];
  assign deq[1] = elig[1] && !elig[0];

  genvar q;
  generate
    for (q = 0; q < EVQ_NQ; q++)
    begin : g_q
      assign elig[q] = (count_ff[q] != 5'h0) &&
                       (!tr_valid_ff[q] || I_TR_READY[q]);
      assign byp[q] = evt_ok && (evt_q == q) && (count_ff[q] == 5'h0) &&
                      I_ENG_EMPTY[q] && !tr_valid_ff[q];
      assign enq[q] = evt_ok && (evt_q == q) && !byp[q];
      assign wr_idx[q] = 4'(head_ff[q] + count_ff[q][3:0]);
      assign nxt_count[q] = 5'(count_ff[q] + {4'h0, enq[q]} -
                               {4'h0, deq[q]});
      assign over_set[q] = nxt_count[q] > {1'b0, thr_ff[q]};
      assign O_TR_VALID[q] = tr_valid_ff[q];
      assign O_TR[q] = '{prio: prio_ff[q], ent: tr_ent_ff[q]};

      always_ff @(posedge I_CLK)
      begin
        if (I_RST)
        begin
          head_ff[q] <= 4'h0;
          count_ff[q] <= 5'h0;
        end
        else
        begin
          count_ff[q] <= nxt_count[q];
          if (deq[q])
          begin
            head_ff[q] <= 4'(head_ff[q] + 4'h1);
          end
        end
      end

      always_ff @(posedge I_CLK)
      begin
        if (I_RST)
        begin
          mark_ff[q] <= 5'h0;
        end
        else if (nxt_count[q] > mark_ff[q])
        begin
          mark_ff[q] <= nxt_count[q];
        end
      end

      // set wins over the read clear so no crossing is lost
      always_ff @(posedge I_CLK)
      begin
        if (I_RST)
        begin
          over_ff[q] <= 1'b0;
        end
        else
        begin
          over_ff[q] <= (over_ff[q] && !err_rd_clr) || over_set[q];
        end
      end

      // request slot held until the engine takes it
      always_ff @(posedge I_CLK)
      begin
        if (I_RST)
        begin
          tr_valid_ff[q] <= 1'b0;
          tr_ent_ff[q] <= '0;
        end
        else if (deq[q])
        begin
          tr_valid_ff[q] <= 1'b1;
          tr_ent_ff[q] <= entry_mem[q][head_ff[q]];
        end
        else if (byp[q])
        begin
          tr_valid_ff[q] <= 1'b1;
          tr_ent_ff[q] <= I_EVT;
        end
        else if (I_TR_READY[q])
        begin
          tr_valid_ff[q] <= 1'b0;
        end
      end
    end
  endgenerate

  // history survives dequeue; only a new write overwrites a slot
  always_ff @(posedge I_CLK)
  begin
    for (int i = 0; i < EVQ_NQ; i++)
    begin
      if (enq[i])
      begin
        entry_mem[i][wr_idx[i]] <= I_EVT;
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      err_ff <= '0;
    end
    else
    begin
      err_ff <= (err_ff & ~{EVQ_NQ{err_rd_clr}}) | over_set;
    end
  end

  assign O_IRQ = |(err_ff & mask_ff);

  // register slave: address and data may come in either order
  assign O_AXI_AWREADY = !aw_got_ff && !bvalid_ff;
  assign O_AXI_WREADY = !w_got_ff && !bvalid_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign O_AXI_BVALID = bvalid_ff;
  assign O_AXI_BRESP = bresp_ff;
  assign O_AXI_ARREADY = !rvalid_ff;
  assign ar_fire = I_AXI_ARVALID && !rvalid_ff;
  assign err_rd_clr = ar_fire && (I_AXI_ARADDR[8:2] == EVQ_OFS_ERR[8:2]);
  assign O_AXI_RVALID = rvalid_ff;
  assign O_AXI_RDATA = rdata_ff;
  assign O_AXI_RRESP = rresp_ff;
  assign wr_hit = aw_addr_ff[8:2] <= EVQ_OFS_MASK[8:2];

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= EVQ_RESP_OKAY;
    end
    else
    begin
      if (I_AXI_AWVALID && O_AXI_AWREADY)
      begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && O_AXI_WREADY)
      begin
        w_got_ff <= 1'b1;
        w_data_ff <= I_AXI_WDATA;
        w_strb_ff <= I_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? EVQ_RESP_OKAY : EVQ_RESP_SLVERR;
      end
      else if (bvalid_ff && I_AXI_BREADY)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read-only status and error words ignore writes but still answer okay
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      dsel_ff <= '0;
      qsel_ff <= '0;
      mask_ff <= EVQ_RST_MASK;
      for (int i = 0; i < EVQ_NQ; i++)
      begin
        thr_ff[i] <= EVQ_RST_THR;
        prio_ff[i] <= EVQ_RST_PRIO;
      end
    end
    else if (wr_fire)
    begin
      case (aw_addr_ff[8:2])
        EVQ_OFS_DSEL_LO[8:2]:
          dsel_ff[31:0] <= merge(dsel_ff[31:0], w_data_ff, w_strb_ff);
        EVQ_OFS_DSEL_HI[8:2]:
          dsel_ff[63:32] <= merge(dsel_ff[63:32], w_data_ff, w_strb_ff);
        EVQ_OFS_QSEL[8:2]:
          if (w_strb_ff[0])
          begin
            qsel_ff <= w_data_ff[7:0];
          end
        EVQ_OFS_THRESH[8:2]:
          for (int i = 0; i < EVQ_NQ; i++)
          begin
            if (w_strb_ff[i])
            begin
              thr_ff[i] <= w_data_ff[i*EVQ_THR_STRIDE +: 4];
            end
          end
        EVQ_OFS_PRIO[8:2]:
          if (w_strb_ff[0])
          begin
            for (int i = 0; i < EVQ_NQ; i++)
            begin
              prio_ff[i] <= w_data_ff[i*EVQ_PRIO_STRIDE +: 3];
            end
          end
        EVQ_OFS_MASK[8:2]:
          if (w_strb_ff[0])
          begin
            mask_ff <= w_data_ff[EVQ_NQ-1:0];
          end
        default:
          ;
      endcase
    end
  end

  always_comb
  begin
    rd_data = 32'h0;
    rd_hit = 1'b1;
    if (I_AXI_ARADDR[8] && !I_AXI_ARADDR[7])
    begin
      rd_data[7:0] = entry_mem[I_AXI_ARADDR[6]][I_AXI_ARADDR[5:2]];
    end
    else
    begin
      case (I_AXI_ARADDR[8:2])
        EVQ_OFS_DSEL_LO[8:2]: rd_data = dsel_ff[31:0];
        EVQ_OFS_DSEL_HI[8:2]: rd_data = dsel_ff[63:32];
        EVQ_OFS_QSEL[8:2]: rd_data[7:0] = qsel_ff;
        EVQ_OFS_THRESH[8:2]:
        begin
          rd_data[3:0] = thr_ff[0];
          rd_data[EVQ_THR_STRIDE +: 4] = thr_ff[1];
        end
        EVQ_OFS_PRIO[8:2]:
        begin
          rd_data[2:0] = prio_ff[0];
          rd_data[EVQ_PRIO_STRIDE +: 3] = prio_ff[1];
        end
        EVQ_OFS_STAT0[8:2]:
          rd_data = stat_word(head_ff[0], count_ff[0], mark_ff[0],
                              over_ff[0]);
        EVQ_OFS_STAT1[8:2]:
          rd_data = stat_word(head_ff[1], count_ff[1], mark_ff[1],
                              over_ff[1]);
        EVQ_OFS_ERR[8:2]: rd_data[EVQ_NQ-1:0] = err_ff;
        EVQ_OFS_MASK[8:2]: rd_data[EVQ_NQ-1:0] = mask_ff;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= EVQ_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_data;
      rresp_ff <= rd_hit ? EVQ_RESP_OKAY : EVQ_RESP_SLVERR;
    end
    else if (I_AXI_RREADY)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  AST_FULL_REFUSE: assert property (@(posedge I_CLK) disable iff (I_RST)
    (count_ff[evt_q] == 5'h10) |-> !O_EVT_READY)
    else $error("full queue still accepting");

  AST_COUNT_BOUND: assert property (@(posedge I_CLK) disable iff (I_RST)
    count_ff[0] <= 5'h10 && count_ff[1] <= 5'h10)
    else $error("queue count above depth");

  AST_BYPASS_UNLOGGED: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    byp[0] |=> count_ff[0] == 5'h0 && tr_valid_ff[0] &&
               tr_ent_ff[0] == $past(I_EVT))
    else $error("bypass event logged or lost");

  AST_Q0_FIRST: assert property (@(posedge I_CLK) disable iff (I_RST)
    (elig[0] && elig[1]) |=>
      head_ff[0] == 4'($past(head_ff[0]) + 4'h1) && $stable(head_ff[1]))
    else $error("second queue served before first");

  AST_ENQ_COUNT: assert property (@(posedge I_CLK) disable iff (I_RST)
    (enq[1] && !deq[1]) |=> count_ff[1] == 5'($past(count_ff[1]) + 5'h1))
    else $error("enqueue did not raise count");

  AST_ENTRY_LOG: assert property (@(posedge I_CLK) disable iff (I_RST)
    enq[0] |=> entry_mem[0][$past(wr_idx[0])] == $past(I_EVT))
    else $error("entry not recorded");

  AST_HIGH_MARK: assert property (@(posedge I_CLK) disable iff (I_RST)
    mark_ff[0] >= count_ff[0] && mark_ff[1] >= count_ff[1])
    else $error("high mark below occupancy");

  AST_OVER_FLAG: assert property (@(posedge I_CLK) disable iff (I_RST)
    (count_ff[0] > {1'b0, thr_ff[0]} && $stable(thr_ff[0])) |->
      err_ff[0] && over_ff[0])
    else $error("over threshold not flagged");

  AST_IRQ_RAISE: assert property (@(posedge I_CLK) disable iff (I_RST)
    ($rose(err_ff[0]) && mask_ff[0]) |-> O_IRQ)
    else $error("error bit without interrupt");

  AST_REQ_HOLD: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_TR_VALID[0] && !I_TR_READY[0]) |=>
      O_TR_VALID[0] && $stable(tr_ent_ff[0]))
    else $error("request dropped before taken");
endmodule : evq_top

// file: core/evq_pkg.sv
// constants, types and register map of the event queue stage
// Overview of operation
// - each of the 64 normal and 8 quick channels picks its queue by a bit.
// - an event whose queue, request slot and engine are all empty skips the queue.
// - each queue is a 16-entry circular first-in first-out buffer.
// - every entry is readable and holds the trigger kind and channel.
// - each queue status shows the index of the current head entry.
// - status shows the valid count; the rest of the entries are history.
// - each queue has a software threshold from 0 to 15.
// - a high mark per queue keeps the largest occupancy seen.
// - going over threshold sets an error bit and a status flag.
// - any set error bit raises the controller error interrupt; here only error bits enabled in the mask register raise it.
// - queue n feeds engine n, and each engine carries a bus priority.
// - the stage issues transfer requests and the engine carries them out.
// - with a full queue, further events stay pending at their source.
// - the head leaves only when its request slot is free or its engine can accept; queue 0 goes first.
package evq_pkg;
  localparam int EVQ_NQ = 2;
  localparam int EVQ_DEPTH = 16;
  localparam int EVQ_NDMA = 64;
  localparam int EVQ_NQUICK = 8;
  localparam int EVQ_AW = 9;
  localparam logic [1:0] EVQ_K_EVENT = 2'h0;
  localparam logic [1:0] EVQ_K_MANUAL = 2'h1;
  localparam logic [1:0] EVQ_K_CHAIN = 2'h2;
  localparam logic [1:0] EVQ_K_QUICK = 2'h3;
  localparam logic [8:0] EVQ_OFS_DSEL_LO = 9'h000;
  localparam logic [8:0] EVQ_OFS_DSEL_HI = 9'h004;
  localparam logic [8:0] EVQ_OFS_QSEL = 9'h008;
  localparam logic [8:0] EVQ_OFS_THRESH = 9'h00c;
  localparam logic [8:0] EVQ_OFS_PRIO = 9'h010;
  localparam logic [8:0] EVQ_OFS_STAT0 = 9'h014;
  localparam logic [8:0] EVQ_OFS_STAT1 = 9'h018;
  localparam logic [8:0] EVQ_OFS_ERR = 9'h01c;
  localparam logic [8:0] EVQ_OFS_MASK = 9'h020;
  localparam logic [8:0] EVQ_OFS_ENTRY = 9'h100;
  localparam int EVQ_POS_COUNT = 8;
  localparam int EVQ_POS_MARK = 16;
  localparam int EVQ_POS_OVER = 24;
  localparam int EVQ_THR_STRIDE = 8;
  localparam int EVQ_PRIO_STRIDE = 4;
  localparam logic [3:0] EVQ_RST_THR = 4'hf;
  localparam logic [2:0] EVQ_RST_PRIO = 3'h0;
  localparam logic [1:0] EVQ_RST_MASK = 2'h3;
  localparam logic [1:0] EVQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] EVQ_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] kind;
    logic [5:0] chan;
  } evq_entry_t;

  typedef struct packed {
    logic [2:0] prio;
    evq_entry_t ent;
  } evq_req_t;
endpackage : evq_pkg

// file: tb/evq_eng_model.sv
// transfer engine stand-in that logs every request it accepts
`timescale 1ns/1ps
module evq_eng_model
  import evq_pkg::*;
#(
  parameter int LAT = 3
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire evq_req_t i_req,
  input wire logic i_stall,
  output logic o_ready,
  output logic o_empty
);
  evq_req_t log_req [0:31];
  int log_t [0:31];
  int log_n;
  int cyc;
  int busy;
  // stall stands for an engine still moving an earlier request
  assign o_ready = !i_stall;
  assign o_empty = (busy == 0);
  always_ff @(posedge i_clk)
  begin
    cyc <= i_rst ? 0 : cyc + 1;
    if (i_rst)
    begin
      log_n <= 0;
      busy <= 0;
    end
    else if (i_valid && o_ready)
    begin
      log_req[log_n] <= i_req;
      log_t[log_n] <= cyc;
      log_n <= log_n + 1;
      busy <= LAT;
    end
    else if (busy > 0)
      busy <= busy - 1;
  end
endmodule : evq_eng_model

// file: tb/testbench.sv
// register and event sequence bench for the event queue stage
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("ERROR %0t: got %h exp %h", $time, g, e); \
    end \
  end
module testbench;
  import evq_pkg::*;
  logic clk, rst, evv, evr, irq;
  logic awv, awr, wv, wr, bv, bry, arv, arr, rv, rry;
  evq_entry_t ev;
  logic [8:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] br, rr, trv, try, emp, stl;
  evq_req_t [1:0] tr;
  int num_errors, comparisons, i;

  evq_top DUT (.I_CLK(clk), .I_RST(rst), .I_EVT_VALID(evv), .I_EVT(ev),
    .O_EVT_READY(evr), .O_TR_VALID(trv), .O_TR(tr), .I_TR_READY(try),
    .I_ENG_EMPTY(emp), .O_IRQ(irq), .I_AXI_AWVALID(awv),
    .O_AXI_AWREADY(awr), .I_AXI_AWADDR(awa), .I_AXI_WVALID(wv),
    .O_AXI_WREADY(wr), .I_AXI_WDATA(wd), .I_AXI_WSTRB(ws),
    .O_AXI_BVALID(bv), .I_AXI_BREADY(bry), .O_AXI_BRESP(br),
    .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr), .I_AXI_ARADDR(ara),
    .O_AXI_RVALID(rv), .I_AXI_RREADY(rry), .O_AXI_RDATA(rdat),
    .O_AXI_RRESP(rr));
  evq_eng_model ENG0 (.i_clk(clk), .i_rst(rst), .i_valid(trv[0]),
    .i_req(tr[0]), .i_stall(stl[0]), .o_ready(try[0]), .o_empty(emp[0]));
  evq_eng_model ENG1 (.i_clk(clk), .i_rst(rst), .i_valid(trv[1]),
    .i_req(tr[1]), .i_stall(stl[1]), .o_ready(try[1]), .o_empty(emp[1]));

  task automatic axw(input logic [8:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    logic ad;
    logic dd;
    ad = 0;
    dd = 0;
    awa <= a;
    wd <= d;
    ws <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge clk);
      if (!ad && awr)
      begin
        ad = 1;
        awv <= 1'b0;
      end
      if (!dd && wr)
      begin
        dd = 1;
        wv <= 1'b0;
      end
    end
    while (!bv)
      @(posedge clk);
    `CHK(br, e)
    bry <= 1'b0;
    @(posedge clk);
  endtask : axw

  task automatic axr(input logic [8:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    `CHK(rdat, d)
    `CHK(rr, e)
    rry <= 1'b0;
    @(posedge clk);
  endtask : axr

  // valid is lowered a full edge before the next offer
  task automatic evt(input logic [1:0] k, input logic [5:0] c);
    ev <= '{kind: k, chan: c};
    evv <= 1'b1;
    do @(posedge clk); while (!evr);
    evv <= 1'b0;
    @(posedge clk);
  endtask : evt

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    rst = 1;
    {evv, awv, wv, bry, arv, rry} = '0;
    ev = '0;
    {awa, ara, wd, ws, stl} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(EVQ_OFS_THRESH, 32'h00000f0f, EVQ_RESP_OKAY);
    axr(EVQ_OFS_PRIO, 32'h0, EVQ_RESP_OKAY);
    axr(EVQ_OFS_MASK, 32'h3, EVQ_RESP_OKAY);
    axr(9'h0f0, 32'h0, EVQ_RESP_SLVERR);
    axw(9'h0f0, 32'h0, EVQ_RESP_SLVERR);
    axw(EVQ_OFS_THRESH, 32'h00000f03, EVQ_RESP_OKAY);
    // first event bypasses into the slot, the next sixteen fill the queue
    stl <= 2'b01;
    for (i = 1; i <= 17; i++)
    begin
      if (i == 5)
        axr(EVQ_OFS_ERR, 32'h0, EVQ_RESP_OKAY);
      evt(2'(i % 4), 6'(i + 8));
    end
    ev <= '{kind: 2'h2, chan: 6'h1e};
    evv <= 1'b1;
    repeat (3)
    begin
      @(posedge clk);
      `CHK(evr, 1'b0)
    end
    axr(EVQ_OFS_STAT0, 32'h01101000, EVQ_RESP_OKAY);
    for (i = 0; i < 16; i++)
      axr(EVQ_OFS_ENTRY + 9'(4 * i), {24'h0, 2'((i + 2) % 4),
          6'(i + 10)}, EVQ_RESP_OKAY);
    `CHK(irq, 1'b1)
    axw(EVQ_OFS_MASK, 32'h0, EVQ_RESP_OKAY);
    `CHK(irq, 1'b0)
    axw(EVQ_OFS_MASK, 32'h3, EVQ_RESP_OKAY);
    stl <= 2'b00;
    do @(posedge clk); while (!evr);
    evv <= 1'b0;
    while (ENG0.log_n < 18)
      @(posedge clk);
    for (i = 0; i < 17; i++)
      `CHK(ENG0.log_req[i], {3'h0, 2'((i + 1) % 4), 6'(i + 9)})
    `CHK(ENG0.log_req[17], 11'h09e)
    axr(EVQ_OFS_STAT0, 32'h01100001, EVQ_RESP_OKAY);
    axr(EVQ_OFS_ERR, 32'h1, EVQ_RESP_OKAY);
    axr(EVQ_OFS_ERR, 32'h0, EVQ_RESP_OKAY);
    axr(EVQ_OFS_STAT0, 32'h00100001, EVQ_RESP_OKAY);
    `CHK(irq, 1'b0)
    // channel routing and per-engine bus priority
    axw(EVQ_OFS_DSEL_LO, 32'h20, EVQ_RESP_OKAY);
    axw(EVQ_OFS_DSEL_HI, 32'h100, EVQ_RESP_OKAY);
    axw(EVQ_OFS_QSEL, 32'h4, EVQ_RESP_OKAY);
    axw(EVQ_OFS_PRIO, 32'h53, EVQ_RESP_OKAY);
    evt(EVQ_K_EVENT, 6'd5);
    evt(EVQ_K_MANUAL, 6'd40);
    evt(EVQ_K_QUICK, 6'd2);
    evt(EVQ_K_CHAIN, 6'd6);
    while (ENG1.log_n < 3 || ENG0.log_n < 19)
      @(posedge clk);
    `CHK(ENG1.log_req[0], {3'h5, EVQ_K_EVENT, 6'd5})
    `CHK(ENG1.log_req[1], {3'h5, EVQ_K_MANUAL, 6'd40})
    `CHK(ENG1.log_req[2], {3'h5, EVQ_K_QUICK, 6'd2})
    `CHK(ENG0.log_req[18], {3'h3, EVQ_K_CHAIN, 6'd6})
    // both queues eligible together: the first queue must win
    stl <= 2'b11;
    evt(EVQ_K_EVENT, 6'd6);
    evt(EVQ_K_EVENT, 6'd5);
    evt(EVQ_K_MANUAL, 6'd7);
    evt(EVQ_K_MANUAL, 6'd5);
    stl <= 2'b00;
    while (ENG0.log_n < 21 || ENG1.log_n < 5)
      @(posedge clk);
    `CHK(ENG0.log_req[20].ent, {EVQ_K_MANUAL, 6'd7})
    `CHK(ENG1.log_req[4].ent, {EVQ_K_MANUAL, 6'd5})
    `CHK(ENG0.log_t[20] < ENG1.log_t[4], 1'b1)
    give_verdict();
  end
endmodule : testbench
